// ==== src/timer_regs.svh ====
// Offsets, field positions, reset values and counts of the interval timer port
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define CHANNEL_COUNT   3
`define COUNT_WIDTH     16
`define PIN_SYNC_WIDTH  19

`define SEL_CTRL        2'h3
`define SC_READBACK     2'h3

`define CW_SC_HI        7
`define CW_SC_LO        6
`define CW_RW_HI        5
`define CW_RW_LO        4
`define RB_COUNT_N      5
`define RB_STATUS_N     4
`define RB_SEL_LO       1

`define STS_OUT         7
`define STS_NULL        6

`define MODE_RESET      6'h30
`define CR_RESET        16'h0000
`define BYTE_RESET      8'h00

`endif

// ==== src/timer_pkg.sv ====
// Types shared by the interval timer read-back logic
package timer_pkg;

    typedef enum logic [1:0] {
        FMT_LATCH = 2'b00,
        FMT_LSB   = 2'b01,
        FMT_MSB   = 2'b10,
        FMT_WORD  = 2'b11
    } rw_fmt_t;

endpackage

// ==== src/timer_count_element.sv ====
// Counting element of one timer channel: clock pulse, trigger and load
`timescale 1ns/1ps
`include "timer_regs.svh"

module timer_count_element #(
    parameter int WIDTH = `COUNT_WIDTH
)(
    // System
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // Synchronised channel pins
    input  wire logic             clk_lvl,
    input  wire logic             gate_lvl,
    // Load control
    input  wire logic             load_req,
    input  wire logic [WIDTH-1:0] holding_value,
    // Results
    output logic      [WIDTH-1:0] ce_value,
    output logic                  out_level,
    output logic                  load_done
);

    logic clk_prev_reg;
    logic rise_seen_reg;
    logic gate_prev_reg;
    logic trig_reg;
    logic pulse;

    // Pulse only after rise then fall
    assign pulse     = rise_seen_reg && clk_prev_reg && !clk_lvl;
    assign load_done = pulse && (load_req || trig_reg);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clk_prev_reg  <= 1'b0;
            rise_seen_reg <= 1'b0;
        end else begin
            clk_prev_reg <= clk_lvl;
            if (!clk_prev_reg && clk_lvl) begin
                rise_seen_reg <= 1'b1;
            end else if (pulse) begin
                rise_seen_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gate_prev_reg <= 1'b0;
            trig_reg      <= 1'b0;
        end else begin
            gate_prev_reg <= gate_lvl;
            if (!gate_prev_reg && gate_lvl) begin
                trig_reg <= 1'b1;
            end else if (pulse) begin
                trig_reg <= 1'b0;
            end
        end
    end

    // Holding value moves in only on a load; else count down while gated
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ce_value  <= '0;
            out_level <= 1'b0;
        end else if (load_done) begin
            ce_value  <= holding_value;
            out_level <= 1'b0;
        end else if (pulse && gate_lvl && ce_value != '0) begin
            ce_value <= ce_value - 1'b1;
            if (ce_value == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                out_level <= 1'b1;
            end
        end
    end

endmodule // timer_count_element

// ==== src/timer_readback.sv ====
// Host port decode, read-back command, count and status latches of a three-channel timer
`timescale 1ns/1ps
`include "timer_regs.svh"

module timer_readback
    import timer_pkg::*;
#(
    parameter int WIDTH = `COUNT_WIDTH
)(
    // System
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // Host parallel port
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [1:0] reg_select,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    // Channel pins
    input  wire logic [2:0] cnt_clk,
    input  wire logic [2:0] cnt_gate,
    output logic      [2:0] cnt_out
);

    localparam int NCH = `CHANNEL_COUNT;

    // Picks the byte a read returns for the given format and byte phase
    function automatic logic [7:0] byte_sel(input logic [15:0] value,
                                            input rw_fmt_t     fmt,
                                            input logic        hi);
        byte_sel = (fmt == FMT_MSB || (fmt == FMT_WORD && hi)) ? value[15:8] : value[7:0];
    endfunction

    // Pin synchronisers
    logic [`PIN_SYNC_WIDTH-1:0] sync1_reg;
    logic [`PIN_SYNC_WIDTH-1:0] sync2_reg;

    logic       cs_n_s;
    logic       rd_n_s;
    logic       wr_n_s;
    logic [1:0] sel_s;
    logic [7:0] data_s;
    logic [2:0] clk_s;
    logic [2:0] gate_s;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync1_reg <= {3'h7, 16'h0000};
            sync2_reg <= {3'h7, 16'h0000};
        end else begin
            sync1_reg <= {cs_n, rd_n, wr_n, reg_select, data_in, cnt_clk, cnt_gate};
            sync2_reg <= sync1_reg;
        end
    end

    assign {cs_n_s, rd_n_s, wr_n_s, sel_s, data_s, clk_s, gate_s} = sync2_reg;

    // Bus cycle decode
    logic       bus_rd;
    logic       bus_wr;
    logic       rd_active_reg;
    logic       wr_active_reg;
    logic [1:0] rd_sel_reg;
    logic [1:0] wr_sel_reg;
    logic [7:0] wr_data_reg;
    logic       rd_done;
    logic       wr_done;

    assign bus_rd  = !cs_n_s && !rd_n_s && wr_n_s && sel_s != `SEL_CTRL;
    assign bus_wr  = !cs_n_s && !wr_n_s && rd_n_s;
    assign rd_done = rd_active_reg && !bus_rd;
    assign wr_done = wr_active_reg && !bus_wr;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_active_reg <= 1'b0;
            rd_sel_reg    <= 2'h0;
        end else begin
            rd_active_reg <= bus_rd;
            if (bus_rd) begin
                rd_sel_reg <= sel_s;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_active_reg <= 1'b0;
            wr_sel_reg    <= 2'h0;
            wr_data_reg   <= `BYTE_RESET;
        end else begin
            wr_active_reg <= bus_wr;
            if (bus_wr) begin
                wr_sel_reg  <= sel_s;
                wr_data_reg <= data_s;
            end
        end
    end

    // Control register commands
    logic    ctrl_wr;
    logic    readback;
    logic    prog;
    logic    cnt_wr;
    rw_fmt_t prog_fmt;

    assign prog_fmt = rw_fmt_t'(wr_data_reg[`CW_RW_HI:`CW_RW_LO]);
    assign ctrl_wr  = wr_done && wr_sel_reg == `SEL_CTRL;
    assign readback = ctrl_wr && wr_data_reg[`CW_SC_HI:`CW_SC_LO] == `SC_READBACK;
    assign prog     = ctrl_wr && !readback && prog_fmt != FMT_LATCH;
    assign cnt_wr   = wr_done && wr_sel_reg != `SEL_CTRL;

    // Per-channel state
    logic [7:0]       rd_byte [NCH];
    logic [WIDTH-1:0] ce_value [NCH];
    logic [NCH-1:0]   out_level;

    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            logic [5:0]       mode_reg;
            logic [WIDTH-1:0] cr_reg;
            logic             wr_msb_reg;
            logic             null_reg;
            logic             armed_reg;
            logic             cnt_latched_reg;
            logic [WIDTH-1:0] ol_reg;
            logic             sts_latched_reg;
            logic [7:0]       sts_reg;
            logic             rd_msb_reg;
            logic             prog_hit;
            logic             rb_sel;
            logic             latch_cnt;
            logic             latch_sts;
            logic             wr_hit;
            logic             rd_hit;
            logic             cr_done;
            logic             loaded;
            logic             cnt_read_end;
            rw_fmt_t          fmt;

            assign fmt       = rw_fmt_t'(mode_reg[5:4]);
            assign prog_hit  = prog && wr_data_reg[`CW_SC_HI:`CW_SC_LO] == 2'(i);
            assign rb_sel    = readback && wr_data_reg[`RB_SEL_LO + i];
            assign latch_cnt = rb_sel && !wr_data_reg[`RB_COUNT_N];
            assign latch_sts = rb_sel && !wr_data_reg[`RB_STATUS_N];
            assign wr_hit    = cnt_wr && wr_sel_reg == 2'(i);
            assign rd_hit    = rd_done && rd_sel_reg == 2'(i);
            assign cr_done   = wr_hit && (fmt != FMT_WORD || wr_msb_reg);
            assign cnt_read_end = rd_hit && !sts_latched_reg && (fmt != FMT_WORD || rd_msb_reg);

            // Mode word, kept for the status byte
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    mode_reg <= `MODE_RESET;
                end else if (prog_hit) begin
                    mode_reg <= wr_data_reg[5:0];
                end
            end

            // Holding register and write byte phase
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    cr_reg     <= `CR_RESET;
                    wr_msb_reg <= 1'b0;
                end else if (prog_hit) begin
                    wr_msb_reg <= 1'b0;
                end else if (wr_hit) begin
                    case (fmt)
                        FMT_LSB: begin
                            cr_reg <= {8'h00, wr_data_reg};
                        end
                        FMT_MSB: begin
                            cr_reg <= {wr_data_reg, 8'h00};
                        end
                        FMT_WORD: begin
                            if (wr_msb_reg) begin
                                cr_reg[15:8] <= wr_data_reg;
                            end else begin
                                cr_reg[7:0] <= wr_data_reg;
                            end
                            wr_msb_reg <= !wr_msb_reg;
                        end
                        default: begin
                            cr_reg <= cr_reg;
                        end
                    endcase
                end
            end

            // Pending-load flag; a set in the load cycle wins
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    null_reg <= 1'b0;
                end else if (prog_hit || cr_done) begin
                    null_reg <= 1'b1;
                end else if (loaded) begin
                    null_reg <= 1'b0;
                end
            end

            // Load stays requested until a complete count has moved in or a control word reprograms the channel
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    armed_reg <= 1'b0;
                end else if (cr_done) begin
                    armed_reg <= 1'b1;
                end else if (prog_hit || loaded) begin
                    armed_reg <= 1'b0;
                end
            end

            // Count latch, independent of the status latch
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    cnt_latched_reg <= 1'b0;
                    ol_reg          <= '0;
                end else if (latch_cnt && !cnt_latched_reg) begin
                    cnt_latched_reg <= 1'b1;
                    ol_reg          <= ce_value[i];
                end else if (prog_hit || cnt_read_end) begin
                    cnt_latched_reg <= 1'b0;
                end
            end

            // Status latch
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    sts_latched_reg <= 1'b0;
                    sts_reg         <= `BYTE_RESET;
                end else if (latch_sts && !sts_latched_reg) begin
                    sts_latched_reg <= 1'b1;
                    sts_reg         <= {out_level[i], null_reg, mode_reg};
                end else if (prog_hit || (rd_hit && sts_latched_reg)) begin
                    sts_latched_reg <= 1'b0;
                end
            end

            // Read byte phase for two-byte counts
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    rd_msb_reg <= 1'b0;
                end else if (prog_hit) begin
                    rd_msb_reg <= 1'b0;
                end else if (rd_hit && !sts_latched_reg && fmt == FMT_WORD) begin
                    rd_msb_reg <= !rd_msb_reg;
                end
            end

            // Status first, then latched count, then live count
            assign rd_byte[i] = sts_latched_reg ? sts_reg :
                                byte_sel(cnt_latched_reg ? ol_reg : ce_value[i], fmt, rd_msb_reg);

            timer_count_element #(
                .WIDTH         (WIDTH)
            ) u_ce (
                .clk_sys       (clk_sys),
                .sys_rst       (sys_rst),
                .clk_lvl       (clk_s[i]),
                .gate_lvl      (gate_s[i]),
                .load_req      (armed_reg),
                .holding_value (cr_reg),
                .ce_value      (ce_value[i]),
                .out_level     (out_level[i]),
                .load_done     (loaded)
            );
        end
    endgenerate

    // Read data drive; undriven outside a valid channel read
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            data_out <= `BYTE_RESET;
            data_oe  <= 1'b0;
        end else begin
            data_oe <= bus_rd;
            if (bus_rd) begin
                data_out <= rd_byte[sel_s];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_out <= 3'h0;
        end else begin
            cnt_out <= out_level;
        end
    end

endmodule // timer_readback

// ==== tb/timer_readback_monitor.sv ====
// Concurrent checks on the timer parallel port and channel outputs
`timescale 1ns/1ps
module timer_readback_monitor (
    // System
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // Host port
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [1:0] reg_select,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    // Channel pins
    input wire logic [2:0] cnt_clk,
    input wire logic [2:0] cnt_gate,
    input wire logic [2:0] cnt_out
);
    wire        rd_act = !cs_n && !rd_n && wr_n && reg_select != 2'h3;
    logic [3:0] quiet_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Cycles since a channel clock pin last moved
    always_ff @(posedge clk_sys) begin
        if (sys_rst || $changed(cnt_clk)) quiet_reg <= 4'h0;
        else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
    end
    a_oe_from_read: assert property (data_oe |-> $past(rd_act, 3))
        else $error("data bus driven without a read");
    a_oe_on_read: assert property (rd_act [*4] |-> data_oe)
        else $error("read not answered");
    a_write_quiet: assert property ((!cs_n && !wr_n) [*4] |-> !data_oe)
        else $error("data bus driven during a write");
    a_ctrl_read_quiet: assert property ((reg_select == 2'h3) [*4] |-> !data_oe)
        else $error("data bus driven for control code");
    a_deselect_quiet: assert property ($rose(cs_n) |-> ##3 !data_oe)
        else $error("data bus driven after deselect");
    a_idle_strobes: assert property ((rd_n && wr_n) [*4] |-> !data_oe)
        else $error("data bus driven with strobes idle");
    a_reset_values: assert property ($fell(sys_rst) |-> data_out == 8'h00 && !data_oe && cnt_out == 3'b000)
        else $error("outputs not at reset values");
    a_out_needs_pulse: assert property (quiet_reg == 4'hf |-> $stable(cnt_out))
        else $error("timer output moved without a clock pulse");
    c_read: cover property (rd_act [*4]);
    c_ctrl_write: cover property ((!cs_n && !wr_n && reg_select == 2'h3) [*4]);
    c_out_rise: cover property ($rose(cnt_out[2]));
endmodule // timer_readback_monitor

bind timer_readback timer_readback_monitor timer_readback_monitor_i (
    .clk_sys, .sys_rst, .cs_n, .rd_n, .wr_n, .reg_select, .data_in,
    .data_out, .data_oe, .cnt_clk, .cnt_gate, .cnt_out
);

// ==== tb/host_bus_model.sv ====
// Host processor model driving the timer parallel port
`timescale 1ns/1ps
module host_bus_model (
    // System
    input  wire logic       clk_sys,
    // Parallel port
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [1:0] reg_select,
    output logic      [7:0] data_in,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    // Completed reads
    output logic            rd_valid,
    output logic      [7:0] rd_data
);
    initial begin
        {cs_n, rd_n, wr_n, rd_valid} = 4'b1110;
        reg_select = 2'h0;
        data_in    = 8'h00;
        rd_data    = 8'h00;
    end
    task automatic bus_write(input logic [1:0] sel, input logic [7:0] d);
        @(posedge clk_sys);
        {cs_n, wr_n} <= 2'b00;
        reg_select   <= sel;
        data_in      <= d;
        repeat (4) @(posedge clk_sys);
        {cs_n, wr_n} <= 2'b11;
        data_in      <= ~d; // Released bus shows no stale value
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic bus_read(input logic [1:0] sel);
        logic got;
        got = 1'b0;
        @(posedge clk_sys);
        {cs_n, rd_n} <= 2'b00;
        reg_select   <= sel;
        for (int i = 0; i < 8 && !got; i++) begin
            @(posedge clk_sys);
            got = (data_oe === 1'b1);
        end
        {cs_n, rd_n} <= 2'b11;
        rd_valid     <= 1'b1;
        rd_data      <= got ? data_out : 8'hxx;
        @(posedge clk_sys);
        rd_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic bus_idle(input logic [1:0] sel, input logic [2:0] crw, output int hits);
        hits = 0;
        @(posedge clk_sys);
        {cs_n, rd_n, wr_n} <= crw;
        reg_select         <= sel;
        repeat (6) begin
            @(posedge clk_sys);
            if (data_oe === 1'b1) hits++;
        end
        {cs_n, rd_n, wr_n} <= 3'b111;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule // host_bus_model

// ==== tb/test_counter_readback_latch.sv ====
// Self-checking bench for the timer read-back and status latches
`timescale 1ns/1ps
module test_counter_readback_latch;
    logic        clk_sys, sys_rst, cs_n, rd_n, wr_n, data_oe, rd_valid;
    logic [1:0]  reg_select;
    logic [7:0]  data_in, data_out, rd_data;
    logic [2:0]  cnt_clk, cnt_gate, cnt_out;
    logic [7:0]  exp_q[$];
    logic [15:0] v [3];
    logic [15:0] n [3];
    logic [4:0]  nops [4] = '{5'b11001, 5'b00101, 5'b00011, 5'b00000};
    int          failures, compares, hits;

    timer_readback timer_readback_i (
        .clk_sys, .sys_rst, .cs_n, .rd_n, .wr_n, .reg_select, .data_in,
        .data_out, .data_oe, .cnt_clk, .cnt_gate, .cnt_out
    );
    host_bus_model host_bus_model_i (
        .clk_sys, .cs_n, .rd_n, .wr_n, .reg_select, .data_in,
        .data_out, .data_oe, .rd_valid, .rd_data
    );

    task automatic end_sim();
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        host_bus_model_i.bus_write(sel, d);
    endtask
    task automatic rd(input logic [1:0] sel, input logic [7:0] e);
        exp_q.push_back(e);
        host_bus_model_i.bus_read(sel);
    endtask
    task automatic wr16(input logic [1:0] sel, input logic [15:0] d);
        wr(sel, d[7:0]);
        wr(sel, d[15:8]);
    endtask
    task automatic rd16(input logic [1:0] sel, input logic [15:0] e);
        rd(sel, e[7:0]);
        rd(sel, e[15:8]);
    endtask
    task automatic pin(input int ch, input logic lvl);
        @(posedge clk_sys);
        cnt_clk[ch] <= lvl;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic pulse(input int ch);
        pin(ch, 1'b1);
        pin(ch, 1'b0);
    endtask
    function automatic logic [7:0] cw(input logic [1:0] ch, input logic [2:0] m);
        return {ch, 2'b11, m, 1'b0};
    endfunction
    function automatic logic [7:0] sts(input logic o, input logic p, input logic [2:0] m);
        return {o, p, 2'b11, m, 1'b0};
    endfunction

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        end_sim();
    end
    // Result watcher: oldest note against each completed read
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            compares++;
            if (exp_q.size() == 0 || rd_data !== exp_q[0]) begin
                failures++;
                $display("[FAIL] %0t read data %h unexpected", $time, rd_data);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end

    initial begin
        sys_rst  = 1'b1;
        cnt_clk  = 3'b000;
        cnt_gate = 3'b000;
        void'($urandom(92));
        for (int i = 0; i < 3; i++) begin
            v[i] = 16'($urandom);
            n[i] = v[i] ^ 16'h5a5a;
        end
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        wr(2'h3, cw(2'h0, 3'd1));
        wr(2'h3, 8'hee);
        rd(2'h0, sts(1'b0, 1'b1, 3'd1));
        rd(2'h1, sts(1'b0, 1'b0, 3'd0));
        rd(2'h2, sts(1'b0, 1'b0, 3'd0));
        wr(2'h3, cw(2'h1, 3'd2));
        wr(2'h3, cw(2'h2, 3'd3));
        for (int i = 0; i < 3; i++) begin
            wr16(2'(i), v[i]);
            pulse(i);
            rd16(2'(i), v[i]);
        end
        wr(2'h3, 8'he2);
        rd(2'h0, sts(1'b0, 1'b0, 3'd1));
        wr(2'h0, n[0][7:0]);
        wr(2'h3, 8'he2);
        rd(2'h0, sts(1'b0, 1'b0, 3'd1));
        wr(2'h0, n[0][15:8]);
        pin(0, 1'b1);
        wr(2'h3, 8'hc2);
        rd(2'h0, sts(1'b0, 1'b1, 3'd1));
        rd16(2'h0, v[0]);
        pin(0, 1'b0);
        rd16(2'h0, n[0]);
        wr(2'h3, 8'hd4);
        wr16(2'h1, n[1]);
        pulse(1);
        wr(2'h3, 8'hc4);
        rd(2'h1, sts(1'b0, 1'b0, 3'd2));
        rd16(2'h1, v[1]);
        rd16(2'h1, n[1]);
        wr(2'h3, 8'he4);
        wr16(2'h1, v[1]);
        wr(2'h3, 8'he4);
        rd(2'h1, sts(1'b0, 1'b0, 3'd2));
        pulse(1);
        wr(2'h3, 8'hda);
        wr16(2'h2, n[2]);
        pulse(2);
        rd(2'h2, v[2][7:0]);
        rd16(2'h0, n[0]);
        rd(2'h2, v[2][15:8]);
        wr(2'h3, 8'hd8);
        wr16(2'h2, v[2]);
        pulse(2);
        wr(2'h3, cw(2'h2, 3'd3));
        rd16(2'h2, v[2]);
        wr(2'h3, 8'he8);
        rd(2'h2, sts(1'b0, 1'b1, 3'd3));
        wr16(2'h2, 16'h0002);
        pulse(2);
        @(posedge clk_sys);
        cnt_gate[2] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        pulse(2);
        rd16(2'h2, 16'h0002);
        pulse(2);
        pulse(2);
        cnt_gate[2] <= 1'b0;
        compares++;
        if (cnt_out !== 3'b100) begin
            failures++;
            $display("[FAIL] %0t timer output %b unexpected", $time, cnt_out);
        end
        wr(2'h3, 8'he8);
        rd(2'h2, sts(1'b1, 1'b0, 3'd3));
        wr(2'h3, 8'h40);
        wr(2'h3, 8'he4);
        rd(2'h1, sts(1'b0, 1'b0, 3'd2));
        wr(2'h3, 8'h56);
        wr(2'h1, n[1][7:0]);
        wr(2'h3, 8'he4);
        rd(2'h1, {1'b0, 1'b1, 6'h16});
        pulse(1);
        rd(2'h1, n[1][7:0]);
        rd(2'h1, n[1][7:0]);
        wr(2'h3, 8'h66);
        wr(2'h1, n[1][15:8]);
        pulse(1);
        rd(2'h1, n[1][15:8]);
        for (int k = 0; k < 4; k++) begin
            host_bus_model_i.bus_idle(nops[k][4:3], nops[k][2:0], hits);
            compares++;
            if (hits != 0) begin
                failures++;
                $display("[FAIL] %0t data bus driven on idle access", $time);
            end
        end
        rd16(2'h0, n[0]);
        repeat (4) @(posedge clk_sys);
        if (exp_q.size() != 0) begin
            failures++;
            $display("[FAIL] %0t reads missing", $time);
        end
        end_sim();
    end
endmodule // test_counter_readback_latch
